// file: rtl/dws_regs.svh
// What this block does
// - eight beats: mode 00, or 01 with chop bit high
// - mode 10 forces four-beat chop always
// - mode 01: per-command bit, low means chop
// - read waits write_to_read_delay after last beat
// - precharge waits write_recovery_time after last beat
// - chopped-on-fly timing starts after all eight beats
// - refresh decode: cs, ras, cas low, we high
// - banks precharged precharge_period before refresh
// - refresh rows from internal counter, address ignored
// - refresh leaves all banks precharged idle
// - only nop or unselect during refresh_cycle_time
// - refreshes average one per average_refresh_interval
// - at most eight refreshes postponed
// - at most eight pulled in
// - at most sixteen refreshes per two intervals
// - self-refresh entry with at most eight owed
// - owed count frozen during self-refresh
// - chop bit never part of column address
`ifndef DWS_REGS_SVH
`define DWS_REGS_SVH
`define DWS_MODE_FIXED8 2'h0
`define DWS_MODE_OTF 2'h1
`define DWS_MODE_FIXED4 2'h2
`define DWS_CLK_NS 20
`define DWS_WTR_NS 8
`define DWS_WR_NS 15
`define DWS_RP_NS 14
`define DWS_RFC_NS 260
`define DWS_REFI_NS 7800
`define DWS_WTR_CYC ((`DWS_WTR_NS + `DWS_CLK_NS - 1) / `DWS_CLK_NS)
`define DWS_WR_CYC ((`DWS_WR_NS + `DWS_CLK_NS - 1) / `DWS_CLK_NS)
`define DWS_RP_CYC ((`DWS_RP_NS + `DWS_CLK_NS - 1) / `DWS_CLK_NS)
`define DWS_RFC_CYC ((`DWS_RFC_NS + `DWS_CLK_NS - 1) / `DWS_CLK_NS)
`define DWS_REFI_CYC (`DWS_REFI_NS / `DWS_CLK_NS)
`define DWS_DEBT_MAX 8
`define DWS_WL 5
`define DWS_BEATS8 8
`define DWS_BEATS4 4
`endif

// file: rtl/dws_pkg.sv
package dws_pkg;
    typedef enum logic [2:0]
    {
        DWS_CMD_NOP = 3'h0,
        DWS_CMD_WRITE = 3'h1,
        DWS_CMD_READ = 3'h2,
        DWS_CMD_PRE = 3'h3,
        DWS_CMD_REF = 3'h4,
        DWS_CMD_SRE = 3'h5,
        DWS_CMD_SRX = 3'h6
    } dws_cmd_t;
    typedef logic [15:0] dws_word_t;
endpackage

// file: rtl/dws_if.sv
`timescale 1ns/100ps
`default_nettype none
interface dws_if;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [14:0] addr;
    logic [15:0] wdata;
    logic wvalid;
    logic wready;
    logic busy;
    modport dev
    (
        input cs_n, ras_n, cas_n, we_n, addr, wdata, wvalid,
        output wready, busy
    );
    modport ctl
    (
        output cs_n, ras_n, cas_n, we_n, addr, wdata, wvalid,
        input wready, busy
    );
endinterface
`default_nettype wire

// file: rtl/dws_device.sv
`timescale 1ns/100ps
`default_nettype none
`include "dws_regs.svh"
module dws_device
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link
    dws_if.dev link,
    // configuration
    input wire logic [1:0] mode_register_zero,
    // user side
    output logic [15:0] data_out,
    output logic data_valid,
    input wire logic data_ready,
    output logic [3:0] burst_beats,
    output logic [9:0] column_out,
    output logic [14:0] refresh_row,
    output logic banks_idle,
    output logic refresh_seen
);
    import dws_pkg::*;
    // ============================================================
    // decode
    logic is_ref;
    logic is_wr;
    assign is_ref = !link.cs_n && !link.ras_n && !link.cas_n && link.we_n;
    assign is_wr = !link.cs_n && link.ras_n && !link.cas_n && !link.we_n;
    function automatic logic chop(input logic [1:0] m, input logic bc);
        chop = (m == `DWS_MODE_FIXED4) || (m == `DWS_MODE_OTF && !bc);
    endfunction
    // ============================================================
    // write data buffer, two entries
    dws_word_t buf_mem [0:1];
    logic [1:0] fill;
    logic wp;
    logic rp;
    logic push;
    logic pop;
    logic take;
    logic [3:0] wbeat;
    assign link.wready = (fill != 2'h2);
    assign take = link.wvalid && link.wready;
    // beats past a chopped burst are taken but not kept
    assign push = take && (wbeat < burst_beats);
    assign pop = data_valid && data_ready;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            fill <= 2'h0;
            wp <= 1'b0;
            rp <= 1'b0;
        end
        else
        begin
            if (push)
                wp <= !wp;
            if (pop)
                rp <= !rp;
            fill <= fill + {1'b0, push} - {1'b0, pop};
        end
    end
    always_ff @(posedge sys_clk)
    begin
        if (push)
            buf_mem[wp] <= link.wdata;
    end
    assign data_valid = (fill != 2'h0);
    assign data_out = buf_mem[rp];
    // ============================================================
    // burst length and column capture
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            burst_beats <= 4'h0;
            column_out <= 10'h000;
        end
        else if (is_wr)
        begin
            burst_beats <= chop(mode_register_zero, link.addr[12]) ?
                4'(`DWS_BEATS4) : 4'(`DWS_BEATS8);
            column_out <= link.addr[9:0];
        end
    end
    // beat count within the current burst
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
            wbeat <= 4'h0;
        else if (is_wr)
            wbeat <= 4'h0;
        else if (take && wbeat != 4'hF)
            wbeat <= wbeat + 4'h1;
    end
    // ============================================================
    // refresh: internal row counter and busy window
    logic [8:0] rfc_cnt;
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            refresh_row <= 15'h0000;
            rfc_cnt <= 9'h000;
            refresh_seen <= 1'b0;
        end
        else
        begin
            refresh_seen <= is_ref;
            if (is_ref)
            begin
                refresh_row <= refresh_row + 15'h0001;
                rfc_cnt <= 9'(`DWS_RFC_CYC);
            end
            else if (rfc_cnt != 9'h000)
                rfc_cnt <= rfc_cnt - 9'h001;
        end
    end
    assign link.busy = (rfc_cnt != 9'h000);
    assign banks_idle = (rfc_cnt == 9'h000);
endmodule
`default_nettype wire

// file: rtl/dws_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "dws_regs.svh"
module dws_controller
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link
    dws_if.ctl link,
    // user side
    input wire logic [1:0] mode_register_zero,
    input wire logic write_req,
    input wire logic chop_sel,
    input wire logic [9:0] column,
    input wire logic [15:0] wr_data,
    input wire logic self_refresh,
    output logic write_ack,
    output logic ref_issued,
    output logic read_ok,
    output logic pre_ok,
    output logic signed [4:0] debt
);
    import dws_pkg::*;
    // ============================================================
    // state and counters
    typedef enum logic [1:0]
    {
        DWS_IDLE = 2'h0,
        DWS_LAT = 2'h1,
        DWS_DATA = 2'h2,
        DWS_RFC = 2'h3
    } dws_st_t;
    dws_st_t st;
    logic [12:0] cnt;
    logic [12:0] refi;
    logic [3:0] beats;
    logic [4:0] wtr;
    logic [4:0] wr;
    logic [4:0] rp;
    logic want_ref;
    logic owed;
    logic rp_done;
    logic link_free;
    logic in_burst;
    logic issue_ref;
    logic ref_room;
    logic [9:0] ref_age [0:15];
    function automatic logic [9:0] age_up(input logic [9:0] a);
        age_up = (a < 10'(2 * `DWS_REFI_CYC)) ? a + 10'h001 : a;
    endfunction
    // ============================================================
    // handshake outputs
    assign owed = (debt > 5'sd0) && !self_refresh;
    assign rp_done = (rp == 5'h00);
    assign link_free = !link.busy;
    // the sixteenth newest refresh must have left the window
    assign ref_room = (ref_age[15] >= 10'(2 * `DWS_REFI_CYC));
    assign want_ref = owed && rp_done && link_free && ref_room;
    assign issue_ref = (st == DWS_IDLE) && want_ref;
    assign write_ack = (st == DWS_IDLE) && write_req && !want_ref &&
        link_free;
    // no read or precharge from the command to the end of the burst
    assign in_burst = (st == DWS_LAT) || (st == DWS_DATA);
    assign read_ok = (wtr == 5'h00) && !in_burst;
    assign pre_ok = (wr == 5'h00) && !in_burst;
    // ============================================================
    // command sequencer
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            st <= DWS_IDLE;
            cnt <= 13'h0000;
            beats <= 4'h0;
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            link.addr <= 15'h0000;
            link.wvalid <= 1'b0;
            link.wdata <= 16'h0000;
            ref_issued <= 1'b0;
            wtr <= 5'h00;
            wr <= 5'h00;
            rp <= 5'(`DWS_RP_CYC);
        end
        else
        begin
            link.cs_n <= 1'b1;
            link.ras_n <= 1'b1;
            link.cas_n <= 1'b1;
            link.we_n <= 1'b1;
            ref_issued <= 1'b0;
            if (wtr != 5'h00)
                wtr <= wtr - 5'h01;
            if (wr != 5'h00)
                wr <= wr - 5'h01;
            if (rp != 5'h00)
                rp <= rp - 5'h01;
            case (st)
                DWS_IDLE:
                begin
                    if (want_ref)
                    begin
                        link.cs_n <= 1'b0;
                        link.ras_n <= 1'b0;
                        link.cas_n <= 1'b0;
                        ref_issued <= 1'b1;
                        cnt <= 13'(`DWS_RFC_CYC);
                        st <= DWS_RFC;
                    end
                    else if (write_req && link_free)
                    begin
                        link.cs_n <= 1'b0;
                        link.cas_n <= 1'b0;
                        link.we_n <= 1'b0;
                        link.addr <= {2'h0, chop_sel, 2'h0, column};
                        // chopped ON_THE_FLY_SELECT still counts eight beats
                        beats <= (mode_register_zero == `DWS_MODE_FIXED4) ?
                            4'(`DWS_BEATS4) : 4'(`DWS_BEATS8);
                        // command and load edges use two latency cycles
                        cnt <= 13'(`DWS_WL - 2);
                        st <= DWS_LAT;
                    end
                end
                DWS_LAT:
                begin
                    if (cnt == 13'h0000)
                        st <= DWS_DATA;
                    else
                        cnt <= cnt - 13'h0001;
                end
                DWS_DATA:
                begin
                    // a stalled beat stays up until taken
                    if (!link.wvalid || link.wready)
                    begin
                        if (beats == 4'h0)
                        begin
                            link.wvalid <= 1'b0;
                            wtr <= 5'(`DWS_WTR_CYC);
                            wr <= 5'(`DWS_WR_CYC);
                            rp <= 5'(`DWS_RP_CYC);
                            st <= DWS_IDLE;
                        end
                        else
                        begin
                            link.wvalid <= 1'b1;
                            link.wdata <= wr_data;
                            beats <= beats - 4'h1;
                        end
                    end
                end
                DWS_RFC:
                begin
                    if (cnt == 13'h0000)
                        st <= DWS_IDLE;
                    else
                        cnt <= cnt - 13'h0001;
                end
                default:
                    st <= DWS_IDLE;
            endcase
        end
    end
    // ============================================================
    // refresh debt tracking
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            refi <= 13'h0000;
            debt <= 5'sd0;
        end
        else if (!self_refresh)
        begin
            refi <= (refi == 13'(`DWS_REFI_CYC - 1)) ? 13'h0000 :
                refi + 13'h0001;
            // debt saturates at eight either way
            if (refi == 13'(`DWS_REFI_CYC - 1) && !ref_issued &&
                debt < 5'sd8)
                debt <= debt + 5'sd1;
            else if (ref_issued && refi != 13'(`DWS_REFI_CYC - 1) &&
                debt > -5'sd8)
                debt <= debt - 5'sd1;
        end
    end
    // ============================================================
    // refresh limiter: ages of the last sixteen refreshes
    always_ff @(posedge sys_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            for (int i = 0; i < 16; i++)
                ref_age[i] <= 10'(2 * `DWS_REFI_CYC);
        end
        else
        begin
            // newest refresh enters slot 0, older ones move down
            ref_age[0] <= issue_ref ? 10'h000 : age_up(ref_age[0]);
            for (int i = 1; i < 16; i++)
                ref_age[i] <= issue_ref ? age_up(ref_age[i - 1]) :
                    age_up(ref_age[i]);
        end
    end
endmodule
`default_nettype wire

// file: testbench/dws_sva.sv
`timescale 1ns/100ps
`default_nettype none
module dws_sva
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic nrst,
    // link
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic wvalid,
    input wire logic wready,
    input wire logic busy
);
    logic rf;
    logic wr;
    logic no_operation_command;
    assign rf = !cs_n && !ras_n && !cas_n && we_n;
    assign wr = !cs_n && ras_n && !cas_n && !we_n;
    assign no_operation_command = cs_n || (ras_n && cas_n && we_n);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    property p_busy; rf |=> busy [*8]; endproperty
    a_busy: assert property (p_busy)
        else $error("no busy after refresh");
    property p_cause; $rose(busy) |-> rf || $past(rf); endproperty
    a_cause: assert property (p_cause)
        else $error("busy without refresh");
    property p_quiet; rf |=> no_operation_command [*8]; endproperty
    a_quiet: assert property (p_quiet)
        else $error("command during refresh");
    property p_quiet_end; rf |-> ##9 no_operation_command [*4]; endproperty
    a_quiet_end: assert property (p_quiet_end)
        else $error("command before refresh end");
    property p_idle; rf |-> !wvalid; endproperty
    a_idle: assert property (p_idle)
        else $error("refresh during burst");
    property p_wl; wr |-> ##5 wvalid; endproperty
    a_wl: assert property (p_wl)
        else $error("first beat not on time");
    property p_wr_gap; wr |=> !wr [*8]; endproperty
    a_wr_gap: assert property (p_wr_gap)
        else $error("write inside burst");
    property p_hold; wvalid && !wready |=> wvalid; endproperty
    a_hold: assert property (p_hold)
        else $error("beat dropped");
endmodule
`default_nettype wire

// file: testbench/dram_write_spacing_and_refresh_bench.sv
`timescale 1ns/100ps
`default_nettype none
`include "dws_regs.svh"
module dram_write_spacing_and_refresh_bench;
    logic sys_clk, nrst, data_ready, write_req, chop_sel, self_refresh;
    logic stall, data_valid, write_ack, read_ok, pre_ok, banks_idle;
    logic refresh_seen, ref_issued;
    logic [1:0] mode;
    logic [9:0] column, column_out;
    logic [15:0] wr_data, data_out;
    logic [3:0] burst_beats;
    logic [14:0] refresh_row, cmd_addr;
    logic signed [4:0] debt, d0;
    int fails, checks_done, seed, beats, refs, keep, r0, seen, issued;
    logic [15:0] words[$];
    dws_if link();
    dws_device dws_device_i (.sys_clk(sys_clk), .nrst(nrst), .link(link),
        .mode_register_zero(mode), .data_out(data_out),
        .data_valid(data_valid), .data_ready(data_ready),
        .burst_beats(burst_beats), .column_out(column_out),
        .refresh_row(refresh_row), .banks_idle(banks_idle),
        .refresh_seen(refresh_seen));
    dws_controller dws_controller_i (.sys_clk(sys_clk), .nrst(nrst),
        .link(link), .mode_register_zero(mode), .write_req(write_req),
        .chop_sel(chop_sel), .column(column), .wr_data(wr_data),
        .self_refresh(self_refresh), .write_ack(write_ack),
        .ref_issued(ref_issued), .read_ok(read_ok), .pre_ok(pre_ok),
        .debt(debt));
    dws_sva dws_sva_i (.sys_clk(sys_clk), .nrst(nrst), .cs_n(link.cs_n),
        .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n),
        .wvalid(link.wvalid), .wready(link.wready), .busy(link.busy));
    initial
    begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fails++;
            $display("mismatch at %0t: %0h %0h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic give_up;
        fails++;
        wrap_up;
    endtask
    // ====================
    // link monitor and reference queue
    always @(posedge sys_clk)
    begin
        data_ready <= stall ? 1'b0 : 1'($random(seed));
        if (!link.cs_n && link.ras_n && !link.cas_n && !link.we_n)
            cmd_addr = link.addr;
        if (!link.cs_n && !link.ras_n && !link.cas_n && link.we_n)
            refs++;
        if (refresh_seen === 1'b1)
            seen++;
        if (ref_issued === 1'b1)
            issued++;
        if (stall && link.wvalid && !link.wready)
        begin
            chk(words.size(), 2);
            stall = 1'b0;
        end
        if (link.wvalid && link.wready && beats < keep)
            words.push_back(link.wdata);
        beats += link.wvalid && link.wready;
        if (data_valid && data_ready && words.size() == 0)
            chk(1, 0);
        else if (data_valid && data_ready)
            chk(data_out, words.pop_front());
    end
    task automatic do_write(input logic [1:0] m, input logic c);
        int n, lag_r, lag_p;
        n = (m == 2'h2) ? 4 : 8;
        @(posedge sys_clk);
        keep = (m == 2'h2 || (m == 2'h1 && !c)) ? 4 : 8;
        mode <= m;
        chop_sel <= c;
        column <= 10'($random(seed));
        wr_data <= 16'($random(seed));
        write_req <= 1'b1;
        repeat (500)
        begin
            @(negedge sys_clk);
            if (write_ack === 1'b1)
                break;
        end
        if (write_ack !== 1'b1)
            give_up;
        beats = 0;
        lag_r = 0;
        lag_p = 0;
        @(posedge sys_clk);
        write_req <= 1'b0;
        repeat (500)
        begin
            @(negedge sys_clk);
            if (link.wvalid === 1'b1)
                chk({read_ok, pre_ok}, 0);
            if (beats == n && read_ok !== 1'b1)
                lag_r++;
            if (beats == n && pre_ok !== 1'b1)
                lag_p++;
            if (beats == n && read_ok === 1'b1 && pre_ok === 1'b1)
                break;
        end
        if (read_ok !== 1'b1)
            give_up;
        chk(beats, n);
        chk(lag_r, `DWS_WTR_CYC);
        chk(lag_p, `DWS_WR_CYC);
        chk(burst_beats, keep);
        chk(column_out, column);
        chk(cmd_addr[9:0], column);
        if (m == 2'h1)
            chk(cmd_addr[12], c);
    endtask
    initial
    begin
        nrst = 1'b0;
        {data_ready, write_req, chop_sel, self_refresh, stall} = 5'h00;
        mode = 2'h0;
        column = 10'h000;
        wr_data = 16'h0000;
        {fails, checks_done, beats, refs, seen, issued} = 0;
        keep = 8;
        seed = 2;
        repeat (4) @(posedge sys_clk);
        nrst <= 1'b1;
        for (int k = 0; k < 6; k++)
            do_write(2'(k % 3), 1'(k / 3));
        stall = 1'b1;
        do_write(2'h0, 1'b1);
        repeat (20) @(negedge sys_clk);
        r0 = refs;
        repeat (3 * `DWS_REFI_CYC) @(negedge sys_clk);
        chk(refs - r0, 3);
        chk(debt, 0);
        chk(banks_idle, 1);
        chk(refresh_row, 15'(refs));
        chk(seen, refs);
        chk(issued, refs);
        @(posedge sys_clk);
        self_refresh <= 1'b1;
        repeat (3) @(negedge sys_clk);
        d0 = debt;
        repeat (3 * `DWS_REFI_CYC) @(negedge sys_clk);
        chk(debt, d0);
        @(posedge sys_clk);
        self_refresh <= 1'b0;
        repeat (50) @(negedge sys_clk);
        chk(debt, 0);
        wrap_up;
    end
endmodule
`default_nettype wire
